// ===== verilog/icd_map.vh
// constants for the instruction class decoder: register map, fields, codes
`ifndef ICD_MAP_VH
`define ICD_MAP_VH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define ICD_OFF_CTRL 12'h000
`define ICD_OFF_OPCODE 12'h004
`define ICD_OFF_CLASS 12'h008
`define ICD_OFF_MODE 12'h00C
`define ICD_OFF_OPER 12'h010
`define ICD_OFF_FLAGS 12'h014
`define ICD_OFF_ID 12'h018
// ****************************************************************
// fields
// ****************************************************************
`define ICD_CTRL_IRQ_BIT 0
`define ICD_CTRL_CCR_LSB 8
`define ICD_CTRL_RESET 32'h0000_0000
// ident value is arbitrary
`define ICD_ID_VALUE 32'h0000_1C0D
// ****************************************************************
// instruction classes (one-hot, none is all zero)
// ****************************************************************
`define ICD_CL_NONE 6'h00
`define ICD_CL_BITBR 6'h01
`define ICD_CL_BITSC 6'h02
`define ICD_CL_BRANCH 6'h04
`define ICD_CL_RMW 6'h08
`define ICD_CL_CTRL 6'h10
`define ICD_CL_REGMEM 6'h20
// ****************************************************************
// addressing modes
// ****************************************************************
`define ICD_M_UNDEF 4'h0
`define ICD_M_TEST_AND_BRANCH 4'h1
`define ICD_M_SET_CLEAR 4'h2
`define ICD_M_RELATIVE 4'h3
`define ICD_M_DIRECT 4'h4
`define ICD_M_IMPLIED 4'h5
`define ICD_M_PTR_BYTE 4'h6
`define ICD_M_PTR_NONE 4'h7
`define ICD_M_LITERAL 4'h8
`define ICD_M_FULL_ADDR 4'h9
`define ICD_M_PTR_WORD 4'hA
// ****************************************************************
// operand selection
// ****************************************************************
`define ICD_OP_NONE 2'h0
`define ICD_OP_ACC 2'h1
`define ICD_OP_INDEX 2'h2
`define ICD_OP_MEM 2'h3
`endif

// ===== verilog/icd_branch_cond.v
// branch condition evaluator for relative and bit-test branches
`timescale 1ns/1ps
module icd_branch_cond (
    // opcode and condition sources
    input wire [7:0] opcode,
    input wire [7:0] mem_byte,
    input wire [4:0] ccr,
    input wire irq_level,
    // result
    output reg taken,
    output reg tested_bit
);
// ****************************************************************
// condition evaluation
// ****************************************************************
// ccr layout: [4]=half carry [3]=mask [2]=negative [1]=zero [0]=carry
wire c = ccr[0];
wire z = ccr[1];
wire n = ccr[2];
wire i = ccr[3];
wire h = ccr[4];
reg raw;
always @* begin
    tested_bit = mem_byte[opcode[3:1]];
    raw = 1'b0;
    if (opcode[7:4] == 4'h0) begin
        // odd row clears, even row sets
        taken = opcode[0] ? ~tested_bit : tested_bit;
    end else begin
        case (opcode[3:1])
            3'h0: raw = 1'b1;
            3'h1: raw = ~(c | z);
            3'h2: raw = ~c;
            3'h3: raw = ~z;
            3'h4: raw = ~h;
            3'h5: raw = ~n;
            3'h6: raw = ~i;
            default: raw = ~irq_level;
        endcase
        // odd opcode inverts the sense of each pair
        taken = opcode[0] ? ~raw : raw;
    end
end
endmodule // icd_branch_cond

// ===== verilog/icd_decoder.v
// instruction class decoder with apb register access
// Functional notes
// - register/memory ops pair accumulator or index with a memory operand
// - jump and jump-subroutine use only an effective address
// - read-modify-write ops write the altered value back to its source
// - negative-or-zero check never writes back
// - relative branches are two bytes; untaken falls through
// - branches on irq pin low and high exist
// - branches on mask clear/set besides carry, zero, negative, half
// - bit set/clear reaches any bit in the lowest 256 bytes
// - each bit op is one opcode with bit number inside it
// - bit test-and-branch copies the tested bit into carry
// - bit branches exist for set and clear, bits zero to seven
// - column 0 test-and-branch, column 1 set/clear, row picks bit
// - subtract with borrow and plain subtract are both decoded
// - bit test ands accumulator with memory, no store
// - rotates pass through carry at both ends
// - control ops act on registers only
// - pointer modes add no, byte or word offset to index
// - relative offset added to pc only when condition true
// - direct addressing uses one byte, lowest 256 bytes
`timescale 1ns/1ps
`include "icd_map.vh"
module icd_decoder (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // pin
    input wire irq_pin
);
// ****************************************************************
// pin synchroniser
// ****************************************************************
// the pin is asynchronous to pclk; only the second flop is read
reg irq_meta_reg;
reg irq_sync_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_meta_reg <= 1'b0;
        irq_sync_reg <= 1'b0;
    end else begin
        irq_meta_reg <= irq_pin;
        irq_sync_reg <= irq_meta_reg;
    end
end
// ****************************************************************
// software registers
// ****************************************************************
reg [31:0] ctrl_reg;
reg [7:0] opcode_reg;
reg [15:0] oper_reg;
wire wr_en = psel & penable & pwrite;
wire [4:0] ccr = ctrl_reg[`ICD_CTRL_CCR_LSB+4:`ICD_CTRL_CCR_LSB];
// software can force the line high; the pin itself lands two edges late
wire irq_level = irq_sync_reg | ctrl_reg[`ICD_CTRL_IRQ_BIT];
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg <= `ICD_CTRL_RESET;
        opcode_reg <= 8'h00;
        oper_reg <= 16'h0000;
    end else if (wr_en) begin
        if (paddr == `ICD_OFF_CTRL) begin
            // unmapped ctrl bits are dropped so they read back as zero
            ctrl_reg <= pwdata & 32'hFF00_1F01;
        end else if (paddr == `ICD_OFF_OPCODE) begin
            opcode_reg <= pwdata[7:0];
        end else if (paddr == `ICD_OFF_OPER) begin
            oper_reg <= pwdata[15:0];
        end
    end
end
// ****************************************************************
// decode
// ****************************************************************
wire [3:0] col = opcode_reg[7:4];
wire [3:0] row = opcode_reg[3:0];
reg [5:0] cls;
reg [3:0] mode;
reg [1:0] src;
reg [1:0] bytes;
reg writes_back;
reg uses_mem;
reg blank;
reg sub_plain;
reg sub_borrow;
// every field but blank defaults to the blank-opcode value: class zero, no effects
always @* begin
    cls = `ICD_CL_NONE;
    mode = `ICD_M_UNDEF;
    src = `ICD_OP_NONE;
    bytes = 2'd1;
    writes_back = 1'b0;
    uses_mem = 1'b0;
    blank = 1'b0;
    sub_plain = 1'b0;
    sub_borrow = 1'b0;
    if (col == 4'h0) begin
        cls = `ICD_CL_BITBR;
        mode = `ICD_M_TEST_AND_BRANCH;
        src = `ICD_OP_MEM;
        bytes = 2'd3;
        uses_mem = 1'b1;
    end else if (col == 4'h1) begin
        cls = `ICD_CL_BITSC;
        mode = `ICD_M_SET_CLEAR;
        src = `ICD_OP_MEM;
        bytes = 2'd2;
        uses_mem = 1'b1;
        writes_back = 1'b1;
    end else if (col == 4'h2) begin
        cls = `ICD_CL_BRANCH;
        mode = `ICD_M_RELATIVE;
        bytes = 2'd2;
    end else if (col >= 4'h3 && col <= 4'h7) begin
        // column 4 row 2 is the unsigned product of index and accumulator
        if (row == 4'h1 || row == 4'h5 || row == 4'hB || row == 4'hE ||
            (row == 4'h2 && col != 4'h4)) begin
            blank = 1'b1;
        end else begin
            cls = `ICD_CL_RMW;
            writes_back = (row != 4'hD);
            if (col == 4'h3) begin
                mode = `ICD_M_DIRECT;
                src = `ICD_OP_MEM;
                bytes = 2'd2;
            end else if (col == 4'h4) begin
                mode = `ICD_M_IMPLIED;
                src = `ICD_OP_ACC;
            end else if (col == 4'h5) begin
                mode = `ICD_M_IMPLIED;
                src = `ICD_OP_INDEX;
            end else if (col == 4'h6) begin
                mode = `ICD_M_PTR_BYTE;
                src = `ICD_OP_MEM;
                bytes = 2'd2;
            end else begin
                mode = `ICD_M_PTR_NONE;
                src = `ICD_OP_MEM;
            end
            uses_mem = (src == `ICD_OP_MEM);
        end
    end else if (col == 4'h8 || col == 4'h9) begin
        if ((col == 4'h8 && (row <= 4'h1 || row == 4'h3 || row >= 4'hE)) ||
            (col == 4'h9 && row >= 4'h7 && row != 4'hE)) begin
            cls = `ICD_CL_CTRL;
            mode = `ICD_M_IMPLIED;
        end else begin
            blank = 1'b1;
        end
    end else begin
        // columns a..f: register/memory group
        if ((col == 4'hA && (row == 4'h7 || row == 4'hC || row == 4'hF))) begin
            blank = 1'b1;
        end else begin
            cls = `ICD_CL_REGMEM;
            uses_mem = 1'b1;
            if (col == 4'hA && row == 4'hD) begin
                // subroutine branch sits in the literal column
                mode = `ICD_M_RELATIVE;
                bytes = 2'd2;
                uses_mem = 1'b0;
            end else begin
                if (col == 4'hA) begin
                    mode = `ICD_M_LITERAL;
                    bytes = 2'd2;
                end else if (col == 4'hB) begin
                    mode = `ICD_M_DIRECT;
                    bytes = 2'd2;
                end else if (col == 4'hC) begin
                    mode = `ICD_M_FULL_ADDR;
                    bytes = 2'd3;
                end else if (col == 4'hD) begin
                    mode = `ICD_M_PTR_WORD;
                    bytes = 2'd3;
                end else if (col == 4'hE) begin
                    mode = `ICD_M_PTR_BYTE;
                    bytes = 2'd2;
                end else begin
                    mode = `ICD_M_PTR_NONE;
                end
            end
            if (row == 4'hC || row == 4'hD) begin
                src = `ICD_OP_NONE;
            end else if (row == 4'h3 || row >= 4'hE) begin
                src = `ICD_OP_INDEX;
            end else begin
                src = `ICD_OP_ACC;
            end
            // store ops write memory; compare and bit test never store
            writes_back = (row == 4'h7 || row == 4'hF);
            // borrow form also takes the carry flag off the accumulator
            sub_plain = (row == 4'h0);
            sub_borrow = (row == 4'h2);
        end
    end
end
// ****************************************************************
// branch condition
// ****************************************************************
// bit branches reuse the address byte as offset: one operand word
// carries only two instruction bytes
wire taken;
wire tested_bit;
icd_branch_cond u_cond (
    .opcode(opcode_reg),
    .mem_byte(oper_reg[15:8]),
    .ccr(ccr),
    .irq_level(irq_level),
    .taken(taken),
    .tested_bit(tested_bit)
);
// ****************************************************************
// effective address and result
// ****************************************************************
reg [15:0] ea;
reg [7:0] rel;
reg [4:0] ccr_out;
reg [7:0] result;
always @* begin
    ea = 16'h0000;
    rel = 8'h00;
    ccr_out = ccr;
    result = oper_reg[15:8];
    if (mode == `ICD_M_DIRECT || mode == `ICD_M_SET_CLEAR ||
        mode == `ICD_M_TEST_AND_BRANCH) begin
        ea = {8'h00, oper_reg[7:0]};
    end else if (mode == `ICD_M_FULL_ADDR) begin
        ea = oper_reg;
    end else if (mode == `ICD_M_PTR_NONE) begin
        ea = {8'h00, ctrl_reg[31:24]};
    end else if (mode == `ICD_M_PTR_BYTE) begin
        ea = {8'h00, ctrl_reg[31:24]} + {8'h00, oper_reg[7:0]};
    end else if (mode == `ICD_M_PTR_WORD) begin
        // the sum wraps at 16 bits, as the address bus does
        ea = oper_reg + {8'h00, ctrl_reg[31:24]};
    end
    if (cls == `ICD_CL_BRANCH || cls == `ICD_CL_BITBR) begin
        // offset added only on a true condition
        rel = taken ? oper_reg[7:0] : 8'h00;
    end
    if (cls == `ICD_CL_BITBR) begin
        ccr_out[0] = tested_bit;
    end else if (cls == `ICD_CL_BITSC) begin
        // bit number is in the opcode, sense from the row parity
        result[row[3:1]] = ~row[0];
    end else if (cls == `ICD_CL_RMW && row == 4'h9) begin
        result = {oper_reg[14:8], ccr[0]};
        ccr_out[0] = oper_reg[15];
    end else if (cls == `ICD_CL_RMW && row == 4'h6) begin
        result = {ccr[0], oper_reg[15:9]};
        ccr_out[0] = oper_reg[8];
    end else if (cls == `ICD_CL_CTRL && col == 4'h9) begin
        if (row == 4'h8) begin
            ccr_out[0] = 1'b0;
        end else if (row == 4'h9) begin
            ccr_out[0] = 1'b1;
        end else if (row == 4'hA) begin
            ccr_out[3] = 1'b0;
        end else if (row == 4'hB) begin
            ccr_out[3] = 1'b1;
        end
    end
end
// ****************************************************************
// apb read path
// ****************************************************************
assign pready = 1'b1;
assign pslverr = 1'b0;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    // captured in the setup cycle so the word stands through the access
    end else if (psel && !penable && !pwrite) begin
        if (paddr == `ICD_OFF_CTRL) begin
            prdata <= ctrl_reg;
        end else if (paddr == `ICD_OFF_OPCODE) begin
            prdata <= {24'h000000, opcode_reg};
        end else if (paddr == `ICD_OFF_CLASS) begin
            prdata <= {16'h0000, 7'h00, blank, 2'h0, cls};
        end else if (paddr == `ICD_OFF_MODE) begin
            prdata <= {8'h00, rel, 2'h0, sub_borrow, sub_plain,
                       writes_back, uses_mem, bytes, 2'h0, src, mode};
        end else if (paddr == `ICD_OFF_OPER) begin
            prdata <= {16'h0000, oper_reg};
        end else if (paddr == `ICD_OFF_FLAGS) begin
            prdata <= {3'h0, taken, 4'h0, result, ea[7:0], 3'h0, ccr_out};
        end else if (paddr == `ICD_OFF_ID) begin
            prdata <= `ICD_ID_VALUE;
        end else begin
            prdata <= 32'h0000_0000;
        end
    end
end
endmodule // icd_decoder

// ===== sim/icd_irq_model.sv
// far-side model of the external interrupt pin source
`timescale 1ns/1ps
module icd_irq_model (
    // control from the bench
    input wire logic pclk,
    input wire logic want_high,
    // pin
    output logic irq_pin
);
    // the pin moves one edge after the request, like a board signal
    initial irq_pin = 1'b0;
    always @(posedge pclk) begin
        irq_pin <= want_high;
    end
endmodule // icd_irq_model

// ===== sim/icd_decoder_props.sv
// assertion checker for the instruction class decoder
`timescale 1ns/1ps
`include "icd_map.vh"
module icd_decoder_props (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [31:0] prdata,
    input wire pslverr,
    // pin
    input wire irq_pin
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****
    // shadow of the last opcode written
    // ****
    logic [7:0] op_reg;
    wire rd_set = psel && !penable && !pwrite;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            op_reg <= 8'h00;
        else if (psel && penable && pwrite && paddr == `ICD_OFF_OPCODE)
            op_reg <= pwdata[7:0];
    end
    property p_ready; psel && penable |-> pready; endproperty
    property p_noerr; psel |-> !pslverr; endproperty
    // read data only moves at a read setup edge
    property p_hold; !rd_set |=> $stable(prdata);
    endproperty
    property p_id; rd_set && paddr == `ICD_OFF_ID |=>
        prdata == `ICD_ID_VALUE; endproperty
    property p_unmap; rd_set && paddr >= 12'h01C |=> prdata == 32'h0;
    endproperty
    property p_opc; rd_set && paddr == `ICD_OFF_OPCODE |=>
        prdata[7:0] == op_reg; endproperty
    property p_hot; rd_set && paddr == `ICD_OFF_CLASS |=>
        $onehot0(prdata[5:0]); endproperty
    property p_blank; rd_set && paddr == `ICD_OFF_CLASS |=>
        !prdata[8] || prdata[5:0] == 6'h00; endproperty
    property p_col; rd_set && paddr == `ICD_OFF_CLASS && op_reg[7:5] == 0
        |=> prdata[5:0] == (op_reg[4] ? `ICD_CL_BITSC : `ICD_CL_BITBR);
    endproperty
    property p_regmem; rd_set && paddr == `ICD_OFF_CLASS &&
        op_reg[7:4] > 4'hA |=> prdata[5:0] == `ICD_CL_REGMEM; endproperty
    property p_rst; $rose(presetn) |-> prdata == 32'h0; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_noerr: assert property (p_noerr) else $error("pslverr high");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_id: assert property (p_id) else $error("bad ident");
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    a_opc: assert property (p_opc) else $error("opcode readback");
    a_hot: assert property (p_hot) else $error("class not one-hot");
    a_blank: assert property (p_blank) else $error("blank has class");
    a_col: assert property (p_col) else $error("bit column class");
    a_regmem: assert property (p_regmem) else $error("reg/mem class");
    a_rst: assert property (p_rst) else $error("read data after reset");
    c_class: cover property (rd_set && paddr == `ICD_OFF_CLASS);
    c_flags: cover property (rd_set && paddr == `ICD_OFF_FLAGS);
    c_ctrl: cover property (psel && pwrite && paddr == `ICD_OFF_CTRL);
endmodule // icd_decoder_props
bind icd_decoder icd_decoder_props u_icd_decoder_props (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .irq_pin);

// ===== sim/tb.sv
// self-checking bench for the instruction class decoder
`timescale 1ns/1ps
`include "icd_map.vh"
module tb;
    // ****
    // signals and bookkeeping
    // ****
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic irq_pin, irq_want, tk, c;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] op, m, off;
    logic [4:0] ccr;
    logic [2:0] bn;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 63402;
    // column to addressing mode, one nibble per column
    localparam logic [63:0] MODES = 64'h76A9_4855_7655_4321;
    icd_decoder u_icd_decoder (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .irq_pin);
    icd_irq_model u_icd_irq_model (.pclk, .want_high(irq_want), .irq_pin);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ****
    // compare, bus tasks, expectations
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 &&
            pready === 1'b1 && exp_q.size() > 0) begin
            check(prdata & msk_q.pop_front(), exp_q.pop_front());
            check({31'h0, pslverr}, 32'h0);
        end
    end
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so the next call never retimes psel in this step
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] k);
        exp_q.push_back(e & k);
        msk_q.push_back(k);
        apb(1'b0, a, 32'h0);
    endtask
    function automatic logic blank(input logic [7:0] o);
        case (o[7:4])
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7: blank = o != 8'h42 &&
                o[3:0] inside {4'h1, 4'h2, 4'h5, 4'hB, 4'hE};
            4'h8: blank = !(o[3:0] inside {4'h0, 4'h1, 4'h3, 4'hE, 4'hF});
            4'h9: blank = o[3:0] < 4'h7 || o[3:0] == 4'hE;
            4'hA: blank = o[3:0] inside {4'h7, 4'hC, 4'hF};
            default: blank = 1'b0;
        endcase
    endfunction
    function automatic logic [5:0] cls(input logic [7:0] o);
        case (o[7:4])
            4'h0: cls = `ICD_CL_BITBR;
            4'h1: cls = `ICD_CL_BITSC;
            4'h2: cls = `ICD_CL_BRANCH;
            4'h8, 4'h9: cls = `ICD_CL_CTRL;
            default: cls = o[7] ? `ICD_CL_REGMEM : `ICD_CL_RMW;
        endcase
    endfunction
    function automatic logic bcond(input logic [7:0] o, input logic [4:0] f,
                                   input logic irq);
        logic t;
        case (o[3:1])
            3'd0: t = 1'b1;
            3'd1: t = !(f[0] | f[1]);
            3'd2: t = !f[0];
            3'd3: t = !f[1];
            3'd4: t = !f[4];
            3'd5: t = !f[2];
            3'd6: t = !f[3];
            default: t = !irq;
        endcase
        bcond = t ^ o[0];
    endfunction
    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // run is a few thousand cycles; this leaves ample margin
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
    // ****
    // main sequence
    // ****
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        irq_want = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`ICD_OFF_CTRL, `ICD_CTRL_RESET, 32'hFFFF_FFFF);
        apb(1'b1, `ICD_OFF_ID, $random(seed));
        rd(`ICD_OFF_ID, `ICD_ID_VALUE, 32'hFFFF_FFFF);
        rd(12'hFFC, 32'h0, 32'hFFFF_FFFF);
        v = $random(seed) & 32'hFF00_1F00;
        apb(1'b1, `ICD_OFF_CTRL, v);
        rd(`ICD_OFF_CTRL, v, 32'hFF00_1F01);
        for (int i = 0; i < 256; i++) begin
            op = i[7:0];
            apb(1'b1, `ICD_OFF_OPCODE, {24'h0, op});
            rd(`ICD_OFF_CLASS, blank(op) ? 32'h100 : {26'h0, cls(op)},
               32'h13F);
            if (!blank(op) && op != 8'hAD)
                rd(`ICD_OFF_MODE, {18'h0, op[7:4] >= 4'hA && op[3:0] == 4'h2,
                   op[7:4] >= 4'hA && op[3:0] == 4'h0, 8'h0,
                   MODES[{op[7:4], 2'b00} +: 4]}, (op[7] && op[3:1] == 3'b110)
                   ? 32'h303F : 32'h300F);
        end
        for (int i = 0; i < 64; i++) begin
            op = {4'h2, i[3:0]};
            ccr = $random(seed);
            {c, off} = $random(seed);
            irq_want <= c;
            apb(1'b1, `ICD_OFF_CTRL, {19'h0, ccr, 8'h0});
            apb(1'b1, `ICD_OFF_OPER, {24'h0, off});
            apb(1'b1, `ICD_OFF_OPCODE, {24'h0, op});
            tk = bcond(op, ccr, c);
            rd(`ICD_OFF_FLAGS, {3'h0, tk, 28'h0}, 32'h1000_0000);
            rd(`ICD_OFF_MODE, {8'h0, tk ? off : 8'h0, 6'h0, 2'd2, 4'h0,
               `ICD_M_RELATIVE}, 32'h00FF_FFFF);
        end
        for (int i = 0; i < 48; i++) begin
            op = i < 32 ? {3'h0, i[4:0]} : (i[0] ? 8'h36 : 8'h39);
            {c, m} = $random(seed);
            bn = op[3:1];
            apb(1'b1, `ICD_OFF_CTRL, {19'h0, 4'h0, c, 8'h0});
            apb(1'b1, `ICD_OFF_OPER, {16'h0, m, 8'hFF});
            apb(1'b1, `ICD_OFF_OPCODE, {24'h0, op});
            if (i >= 32)
                rd(`ICD_OFF_FLAGS, {8'h0, op[0] ? {m[6:0], c} : {c, m[7:1]},
                   15'h0, op[0] ? m[7] : m[0]}, 32'h00FF_0001);
            else if (!op[4])
                rd(`ICD_OFF_FLAGS, {3'h0, m[bn] ^ op[0], 27'h0, m[bn]},
                   32'h1000_0001);
            else
                rd(`ICD_OFF_FLAGS, {8'h0, op[0] ? m & ~(8'h1 << bn) :
                   m | (8'h1 << bn), 8'hFF, 8'h0}, 32'h00FF_FF00);
        end
        apb(1'b1, `ICD_OFF_OPCODE, 32'h3D);
        rd(`ICD_OFF_MODE, 32'h0, 32'h800);
        apb(1'b1, `ICD_OFF_OPCODE, 32'h3C);
        rd(`ICD_OFF_MODE, 32'h800, 32'h800);
        repeat (3) @(posedge pclk);
        print_verdict();
    end
endmodule // tb
